/* hw/bdcx_engine.sv */
/*
 * Debug command executor: takes command bytes from the link layer,
 * runs trace, repeat read, status, PC sample, memory and register
 * write accesses, and returns answer bytes, acknowledge pulses and flags.
 * Assumes a byte-level link layer and internal bus on the same clock.
 */
`timescale 1ns/1ps
`include "bdcx_consts.svh"

module bdcx_engine
    import bdcx_pkg::*;
#(
    parameter bit TRACE_PRESENT = 1'b1          // Trace buffer built in
) (
    input  wire logic          clk_sys_i,       // System clock, 25 MHz
    input  wire logic          reset_i,         // Synchronous reset
    input  wire logic          rx_valid_i,      // Command byte strobe
    input  wire logic [7:0]    rx_byte_i,       // Command byte
    input  wire logic          sync_i,          // Realign pulse seen
    input  wire logic          hs_en_i,         // Handshake enabled
    input  wire logic          tx_ready_i,      // Link took answer byte
    output logic               tx_valid_o,      // Answer byte valid
    output logic [7:0]         tx_byte_o,       // Answer byte
    output logic               ack_o,           // Acknowledge pulse
    output logic               illegal_resp_o,  // Illegal response pulse
    output logic               busy_o,          // Command in progress
    input  wire logic [15:0]   csr_i,           // debug_control_status_reg
    input  wire logic          flag_clr_i,      // Clear the three flags
    output logic               illegal_command_flag_o,
    output logic               no_response_flag_o,
    output logic               illegal_access_flag_o,
    input  wire logic          background_debug_mode_i, // Halted
    input  wire logic          clock_in_stop_option_i,  // Clock runs in stop
    input  wire logic          external_hold_request_i, // Bus held
    input  wire logic          cpu_in_wait_i,   // Pause instruction active
    input  wire logic          cpu_in_stop_i,   // Stop instruction active
    input  wire logic [23:0]   cpu_pc_cur_i,    // Executing address
    input  wire logic [23:0]   cpu_pc_next_i,   // Resume address
    output bdcx_reg_wr_t       reg_wr_o,        // CPU register write
    input  wire logic          reg_done_i,      // Register write done
    output bdcx_mem_req_t      mem_o,           // Internal bus request
    input  wire logic          mem_done_i,      // Bus access done
    input  wire logic          mem_err_i,       // Illegal address
    input  wire logic [31:0]   mem_rdata_i,     // Read data, low aligned
    output logic               trace_req_o,     // Trace access request
    output logic               trace_half_o,    // 1: line bits 63:32
    input  wire logic          trace_valid_i,   // Trace data ready
    input  wire logic [63:0]   trace_line_i     // Trace line
);

    // ==================================================
    // Helpers
    // Bytes of a sized access
    function automatic logic [2:0] nbytes(input logic [1:0] sz);
        nbytes = (sz == 2'h0) ? 3'h1 : (sz == 2'h1) ? 3'h2 : 3'h4;
    endfunction : nbytes

    // Left-justify answer: optional status, then data MSB first
    function automatic logic [39:0] pack(input logic ws, input logic [7:0] st,
                                         input logic [31:0] d, input logic [2:0] n);
        logic [31:0] t;
        t = d << {(3'h4 - n), 3'h0};
        pack = ws ? {st, t} : {t, 8'h00};
    endfunction : pack

    // ==================================================
    // State
    bdcx_state_t  state_q;       // Engine state
    bdcx_kind_t   kind_q;        // Command class
    logic [7:0]   op_q;          // Opcode
    logic [1:0]   sz_q;          // Access size
    logic         ws_q;          // With-status variant
    logic         rej_q;         // Register write rejected
    logic         half_q;        // Second trace longword
    logic         seq_ok_q;      // Repeat read allowed
    logic [23:0]  addr_q;        // Held access address
    logic [31:0]  wdata_q;       // Collected operand
    logic [2:0]   bcnt_q;        // Bytes still to collect
    logic [39:0]  tx_buf_q;      // Answer bytes
    logic [2:0]   tx_left_q;     // Answer bytes left
    logic [4:0]   dly_q;         // Delay counter
    logic [8:0]   tmo_q;         // Access timeout counter
    logic         ill_cmd_q;     // Flags
    logic         no_resp_q;
    logic         ill_acc_q;
    logic         ack_q;         // Acknowledge pulse
    logic         ill_resp_q;    // Illegal response pulse

    // ==================================================
    // Decode of the incoming opcode
    logic       dec;             // Opcode taken
    logic       is_trace, is_same, is_stat, is_pc, is_wr, is_rd, is_regw, is_nop;
    logic       acc_ok, tmo, fin, pc_ok, last_tx;
    logic [31:0] res;            // Access result
    logic [2:0]  res_n;          // Result bytes

    assign dec      = (state_q == ST_IDLE) && rx_valid_i;
    assign is_trace = rx_byte_i == `BDCX_OP_TRACE;
    assign is_same  = rx_byte_i[7:1] == `BDCX_OP_SAME;
    assign is_stat  = rx_byte_i == `BDCX_OP_STAT;
    assign is_pc    = rx_byte_i == `BDCX_OP_PC;
    assign is_nop   = rx_byte_i == `BDCX_OP_NOP;
    assign is_wr    = (rx_byte_i[7:4] == `BDCX_HI_WRITE) && !rx_byte_i[1]
                      && (rx_byte_i[3:2] != 2'h3);
    assign is_rd    = (rx_byte_i[7:4] == `BDCX_HI_READ) && !rx_byte_i[1]
                      && (rx_byte_i[3:2] != 2'h3);
    assign is_regw  = rx_byte_i[7:4] == `BDCX_HI_REGW;

    // Sample blocked while paused, stopped unclocked or held
    assign pc_ok = !cpu_in_wait_i && !external_hold_request_i
                   && !(cpu_in_stop_i && !clock_in_stop_option_i);

    // Completion of the current access
    always_comb begin
        case (kind_q)
            // No trace buffer completes at once
            K_TRACE: acc_ok = !TRACE_PRESENT || trace_valid_i;
            K_MEMRD, K_SAME, K_MEMWR: acc_ok = mem_done_i;
            K_PC:    acc_ok = pc_ok;
            K_REGW:  acc_ok = reg_done_i;
            default: acc_ok = 1'b1;
        endcase
    end
    assign tmo = (tmo_q == `BDCX_TMO_CYC) && !acc_ok;
    assign fin = (state_q == ST_ACCESS) && (acc_ok || tmo);

    // Result of the access
    always_comb begin
        res   = 32'h0000_0000;
        res_n = 3'h0;
        case (kind_q)
            K_TRACE: begin
                res   = !TRACE_PRESENT ? 32'h0000_0000 :
                        half_q ? trace_line_i[63:32] : trace_line_i[31:0];
                res_n = 3'h4;
            end
            K_MEMRD, K_SAME: begin
                res   = (tmo || mem_err_i) ? {4{`BDCX_ERR_BYTE}} : mem_rdata_i;
                res_n = nbytes(sz_q);
            end
            K_STAT: begin
                res   = {16'h0000, csr_i};
                res_n = 3'h2;
            end
            K_PC: begin
                // Resume address when halted or clocked stop
                res   = tmo ? {4{`BDCX_ERR_BYTE}} :
                        (background_debug_mode_i || cpu_in_stop_i)
                        ? {8'h00, cpu_pc_next_i} : {8'h00, cpu_pc_cur_i};
                res_n = 3'h3;
            end
            default: begin
                res   = 32'h0000_0000;
                res_n = 3'h0;
            end
        endcase
    end
    assign last_tx = (state_q == ST_SEND) && tx_ready_i && (tx_left_q == 3'h1);

    // ==================================================
    // Main sequencer
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q   <= ST_IDLE;
            kind_q    <= K_STAT;
            op_q      <= 8'h00;
            sz_q      <= 2'h0;
            ws_q      <= 1'b0;
            rej_q     <= 1'b0;
            half_q    <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            bcnt_q    <= 3'h0;
            tx_buf_q  <= 40'h00_0000_0000;
            tx_left_q <= 3'h0;
            dly_q     <= 5'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    half_q <= 1'b0;
                    if (rx_valid_i) begin
                        op_q <= rx_byte_i;
                        sz_q <= rx_byte_i[3:2];
                        // Status bit means with-status only for memory commands
                        ws_q <= rx_byte_i[0] && (is_same || is_wr || is_rd);
                        if (is_trace) begin
                            kind_q  <= K_TRACE;
                            state_q <= ST_ACCESS;
                        end else if (is_same) begin
                            kind_q <= K_SAME;
                            if (seq_ok_q) begin
                                state_q <= ST_ACCESS;
                            end else begin
                                // Invalid repeat read gives error bytes
                                tx_buf_q  <= {5{`BDCX_ERR_BYTE}};
                                tx_left_q <= nbytes(rx_byte_i[3:2]);
                                state_q   <= ST_SEND;
                            end
                        end else if (is_stat || is_pc) begin
                            kind_q  <= is_stat ? K_STAT : K_PC;
                            state_q <= ST_ACCESS;
                        end else if (is_wr || is_rd) begin
                            kind_q  <= is_wr ? K_MEMWR : K_MEMRD;
                            bcnt_q  <= {1'b0, `BDCX_ADDR_N};
                            state_q <= ST_ADDR;
                        end else if (is_regw) begin
                            kind_q  <= K_REGW;
                            rej_q   <= !background_debug_mode_i;
                            bcnt_q  <= 3'h4;
                            state_q <= ST_WDATA;
                        end
                    end
                end
                ST_ADDR: begin
                    if (rx_valid_i) begin
                        bcnt_q <= bcnt_q - 3'h1;
                        if (bcnt_q == 3'h1) begin
                            bcnt_q  <= nbytes(sz_q);
                            state_q <= (kind_q == K_MEMWR) ? ST_WDATA : ST_ACCESS;
                        end
                    end
                end
                ST_WDATA: begin
                    if (rx_valid_i) begin
                        wdata_q <= {wdata_q[23:0], rx_byte_i};
                        bcnt_q  <= bcnt_q - 3'h1;
                        if (bcnt_q == 3'h1) begin
                            // Rejected or bad number: no write
                            state_q <= (kind_q == K_REGW && (rej_q
                                        || op_q[3:0] >= `BDCX_CRN_BAD))
                                       ? ST_IDLE : ST_ACCESS;
                        end
                    end
                end
                ST_ACCESS: begin
                    if (fin) begin
                        tx_buf_q  <= pack(ws_q && kind_q != K_STAT, csr_i[7:0],
                                          res, res_n);
                        tx_left_q <= res_n + {2'b00, ws_q && kind_q != K_STAT};
                        dly_q     <= `BDCX_DLY_CYC;
                        if (kind_q == K_STAT || (ws_q && kind_q != K_TRACE
                            && kind_q != K_PC && kind_q != K_REGW)) begin
                            state_q <= ST_DELAY;
                        end else if (kind_q == K_MEMWR || kind_q == K_REGW) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_SEND;
                        end
                    end
                end
                ST_DELAY: begin
                    dly_q <= dly_q - 5'h01;
                    if (dly_q == 5'h01) begin
                        state_q <= (kind_q == K_TRACE) ? ST_ACCESS : ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (tx_ready_i) begin
                        tx_buf_q  <= {tx_buf_q[31:0], 8'h00};
                        tx_left_q <= tx_left_q - 3'h1;
                        if (tx_left_q == 3'h1) begin
                            if (kind_q == K_TRACE && !half_q) begin
                                half_q  <= 1'b1;
                                dly_q   <= `BDCX_DLY_CYC;
                                state_q <= hs_en_i ? ST_ACCESS : ST_DELAY;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Held address; aligned for longwords as it arrives
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            addr_q <= 24'h00_0000;
        end else if (state_q == ST_ADDR && rx_valid_i) begin
            // Longword address forced to multiple of four
            addr_q <= {addr_q[15:0], (bcnt_q == 3'h1 && sz_q == `BDCX_SZ_LONG)
                       ? {rx_byte_i[7:2], 2'b00} : rx_byte_i};
        end
    end

    // Repeat-read permission
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            seq_ok_q <= 1'b0;
        end else if (sync_i) begin
            seq_ok_q <= 1'b1;
        end else if (dec && !(is_nop || is_same || is_rd)) begin
            // No-operation leaves pointer and permission intact
            seq_ok_q <= 1'b0;
        end else if (fin && (kind_q == K_MEMRD || kind_q == K_SAME)) begin
            seq_ok_q <= !(tmo || mem_err_i);
        end
    end

    // Timeout counter for internal accesses
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || state_q != ST_ACCESS || fin) begin
            tmo_q <= 9'h000;
        end else begin
            tmo_q <= tmo_q + 9'h001;
        end
    end

    // Sticky flags: setting wins over clearing
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ill_cmd_q <= 1'b0;
            no_resp_q <= 1'b0;
            ill_acc_q <= 1'b0;
        end else begin
            ill_cmd_q <= (ill_cmd_q && !flag_clr_i) || (dec && is_same && !seq_ok_q)
                         || (dec && is_regw && !background_debug_mode_i);
            no_resp_q <= (no_resp_q && !flag_clr_i) || (fin && tmo);
            ill_acc_q <= (ill_acc_q && !flag_clr_i)
                         || (fin && mem_err_i && kind_q != K_TRACE && kind_q != K_PC)
                         || (state_q == ST_WDATA && rx_valid_i && bcnt_q == 3'h1
                             && kind_q == K_REGW && !rej_q
                             && op_q[3:0] >= `BDCX_CRN_BAD);
        end
    end

    // Acknowledge and illegal response pulses
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ack_q      <= 1'b0;
            ill_resp_q <= 1'b0;
        end else begin
            ack_q      <= fin && hs_en_i && kind_q != K_STAT && !ws_q;
            ill_resp_q <= (dec && is_same && !seq_ok_q)
                          || (dec && is_regw && !background_debug_mode_i);
        end
    end

    // ==================================================
    // Outputs
    assign tx_valid_o             = state_q == ST_SEND;
    assign tx_byte_o              = tx_buf_q[39:32];
    assign ack_o                  = ack_q;
    assign illegal_resp_o         = ill_resp_q;
    assign busy_o                 = state_q != ST_IDLE;
    assign illegal_command_flag_o = ill_cmd_q;
    assign no_response_flag_o     = no_resp_q;
    assign illegal_access_flag_o  = ill_acc_q;
    // Repeat read uses the held address
    assign mem_o.req   = state_q == ST_ACCESS && (kind_q == K_MEMRD
                         || kind_q == K_SAME || kind_q == K_MEMWR);
    assign mem_o.we    = kind_q == K_MEMWR;
    assign mem_o.size  = sz_q;
    assign mem_o.addr  = addr_q;
    assign mem_o.wdata = wdata_q;
    assign reg_wr_o.we   = state_q == ST_ACCESS && kind_q == K_REGW;
    assign reg_wr_o.num  = op_q[3:0];
    assign reg_wr_o.data = wdata_q;
    assign trace_req_o   = state_q == ST_ACCESS && kind_q == K_TRACE && TRACE_PRESENT;
    assign trace_half_o  = half_q;

    // ==================================================
    // Checks
    a_trace_low: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        fin && kind_q == K_TRACE && !half_q && TRACE_PRESENT
        |=> tx_buf_q[39:8] == $past(trace_line_i[31:0]))
        else $error("trace low longword not first");
    a_trace_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        fin && kind_q == K_TRACE && !TRACE_PRESENT |=> tx_buf_q[39:8] == 32'h0)
        else $error("absent trace not zero");
    a_trace_ack: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        last_tx && kind_q == K_TRACE && !half_q && hs_en_i |=> state_q == ST_ACCESS)
        else $error("second trace longword not accessed");
    a_same_ill: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        dec && is_same && !seq_ok_q |=> ill_cmd_q && illegal_resp_o)
        else $error("invalid repeat read not flagged");
    a_stat_word: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        fin && kind_q == K_STAT |=> tx_buf_q[39:24] == $past(csr_i) ##1
        state_q == ST_DELAY)
        else $error("status word wrong");
    a_pc_err: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        fin && kind_q == K_PC && tmo |=> no_resp_q && tx_buf_q[39:16] == 24'hEEEEEE)
        else $error("pc timeout not reported");
    a_ack_done: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ack_o |-> $past(fin) && $past(hs_en_i))
        else $error("ack without completion");
    a_long_align: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        mem_o.req && mem_o.size == `BDCX_SZ_LONG |-> mem_o.addr[1:0] == 2'b00)
        else $error("longword address unaligned");
    a_regw_guard: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        reg_wr_o.we |-> !rej_q && reg_wr_o.num < `BDCX_CRN_BAD)
        else $error("illegal register write");
    c_trace_full: cover property (@(posedge clk_sys_i) last_tx && half_q);
    c_pc_tmo: cover property (@(posedge clk_sys_i) fin && kind_q == K_PC && tmo);
    c_wr_ws: cover property (@(posedge clk_sys_i) last_tx && kind_q == K_MEMWR);

endmodule : bdcx_engine

/* hw/bdcx_consts.svh */
/*
 * Constants of the debug command executor: opcodes, sizes, fill bytes
 * and cycle counts. Assumes inclusion by bare name from the module;
 * the package does not include it.
 */
// Function
// - Trace line sent low longword first, MSB first
// - No trace buffer returns zero bytes
// - Acknowledge before each trace longword
// - Repeat read reuses last read address
// - Repeat read illegal after other commands
// - No-operation keeps held address pointer
// - Status read returns 16 bits, high first
// - PC sample returns 24 bits, MSB first
// - PC sample timeout gives error bytes
// - Clocked stop samples following instruction
// - Current or resume address by mode
// - Status write variants return low status
// - Write acknowledge after completion or abort
// - Longword accesses force aligned address
// - Register write sends operand to register
// - Register accesses are always 32 bits
// - Register write outside background rejected
// - Failed reads return error byte each
// - Register numbers D..F are illegal accesses
`ifndef BDCX_CONSTS_SVH
`define BDCX_CONSTS_SVH

// ==================================================
// Opcodes
`define BDCX_OP_TRACE   8'h07
`define BDCX_OP_STAT    8'h2D
`define BDCX_OP_PC      8'h01
`define BDCX_OP_NOP     8'h00
`define BDCX_OP_SAME    7'h2A
`define BDCX_HI_WRITE   4'h1
`define BDCX_HI_READ    4'h3
`define BDCX_HI_REGW    4'h4

// ==================================================
// Values and counts
`define BDCX_ERR_BYTE   8'hEE
`define BDCX_CRN_BAD    4'hD
`define BDCX_SZ_LONG    2'h2
`define BDCX_DLY_CYC    5'h10
`define BDCX_TMO_CYC    9'h100
`define BDCX_ADDR_N     2'h3

`endif

/* hw/bdcx_pkg.sv */
/*
 * Types of the debug command executor.
 * Assumes the constants header sits beside it.
 */
package bdcx_pkg;
    // Command engine states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_WDATA  = 3'b010,
        ST_ACCESS = 3'b011,
        ST_DELAY  = 3'b100,
        ST_SEND   = 3'b101
    } bdcx_state_t;

    // Command classes
    typedef enum logic [2:0] {
        K_TRACE = 3'b000,
        K_MEMRD = 3'b001,
        K_SAME  = 3'b010,
        K_MEMWR = 3'b011,
        K_STAT  = 3'b100,
        K_PC    = 3'b101,
        K_REGW  = 3'b110
    } bdcx_kind_t;

    // Internal bus request
    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } bdcx_mem_req_t;

    // CPU register write
    typedef struct packed {
        logic        we;
        logic [3:0]  num;
        logic [31:0] data;
    } bdcx_reg_wr_t;
endpackage : bdcx_pkg

/* testbench/bdcx_bus_model.sv */
/*
 * Far-side responder for bus, trace and register accesses.
 * Assumes the engine runs on the same clock.
 */
`timescale 1ns/1ps
module bdcx_bus_model
    import bdcx_pkg::*;
(
    input  wire logic     clk_sys_i,    // System clock
    input  bdcx_mem_req_t mem_i,        // Bus request
    input  wire logic     trace_req_i,  // Trace request
    input  bdcx_reg_wr_t  reg_wr_i,     // Register write
    output logic          done_o,       // Answer pulse
    output logic [31:0]   rdata_o       // Read data
);
    logic [1:0] cnt_q = 2'h0;           // Wait cycles
    // Answer three cycles after any request
    always_ff @(posedge clk_sys_i) begin
        cnt_q <= done_o ? 2'h0 : cnt_q + {1'b0, mem_i.req | trace_req_i | reg_wr_i.we};
    end
    assign done_o = (cnt_q == 2'h3);
    // Data valid only while answering
    assign rdata_o = done_o ? {8'hA5, mem_i.addr} : ~{8'hA5, mem_i.addr};
endmodule : bdcx_bus_model

/* testbench/bdcx_engine_test.sv */
/* Command-level bench for the debug executor. Assumes the bus model. */
`timescale 1ns/1ps
module bdcx_engine_test
    import bdcx_pkg::*;
;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, rx_valid_i = 1'b0, sync_i = 1'b0, hs_en_i = 1'b0;
    logic tx_ready_i = 1'b1, flag_clr_i = 1'b0, background_debug_mode_i = 1'b0, done;
    logic clock_in_stop_option_i = 1'b0, external_hold_request_i = 1'b0, cpu_in_wait_i = 1'b0;
    logic cpu_in_stop_i = 1'b0, mem_err_i = 1'b0, tx_valid_o, ack_o, illegal_resp_o, busy_o;
    logic illegal_command_flag_o, no_response_flag_o, illegal_access_flag_o, trace_req_o;
    logic [7:0]   rx_byte_i = 8'h00, tx_byte_o;
    logic [15:0]  csr_i = 16'h5AC3;
    logic [23:0]  cpu_pc_cur_i = 24'h111111, cpu_pc_next_i = 24'h3C4D5E;
    logic [31:0]  rdata;
    logic [63:0]  trace_line_i = 64'h0123456789ABCDEF;
    bdcx_reg_wr_t reg_wr_o;
    bdcx_mem_req_t mem_o;
    int mismatches = 0, cmp_count = 0, acks = 0, writes = 0;
    bdcx_engine bdcx_engine_inst (.clk_sys_i, .reset_i, .rx_valid_i, .rx_byte_i, .sync_i,
        .hs_en_i, .tx_ready_i, .tx_valid_o, .tx_byte_o, .ack_o, .illegal_resp_o, .busy_o, .csr_i,
        .flag_clr_i, .illegal_command_flag_o, .no_response_flag_o, .illegal_access_flag_o,
        .background_debug_mode_i, .clock_in_stop_option_i, .external_hold_request_i,
        .cpu_in_wait_i, .cpu_in_stop_i, .cpu_pc_cur_i, .cpu_pc_next_i, .reg_wr_o,
        .reg_done_i(done), .mem_o, .mem_done_i(done), .mem_err_i, .mem_rdata_i(rdata),
        .trace_req_o, .trace_half_o(), .trace_valid_i(done), .trace_line_i);
    bdcx_bus_model bdcx_bus_model_inst (.clk_sys_i, .mem_i(mem_o), .trace_req_i(trace_req_o),
        .reg_wr_i(reg_wr_o), .done_o(done), .rdata_o(rdata));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        acks += (ack_o === 1'b1);
        writes += (reg_wr_o.we === 1'b1 && done === 1'b1);
    end
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys_i);
        rx_valid_i <= 1'b1;
        rx_byte_i <= b;
        @(posedge clk_sys_i);
        rx_valid_i <= 1'b0;
    endtask : send
    task automatic send_seq(input logic [39:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) send(v[8*i +: 8]);
    endtask : send_seq
    task automatic get(input logic [7:0] e);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (tx_valid_o !== 1'b1 && n < 400);
        chk("answer byte", {16'h0, e}, {16'h0, tx_byte_o});
        @(posedge clk_sys_i);
    endtask : get
    task automatic idle();
        do @(negedge clk_sys_i); while (busy_o !== 1'b0);
        @(posedge clk_sys_i);
    endtask : idle
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial begin
        #(40 * 6000);
        mismatches++;
        complete_run();
    end
    initial begin
        logic [63:0] w;
        logic [31:0] rd;
        w = {trace_line_i[31:0], trace_line_i[63:32]};
        rd = 32'hA512_3454;
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        send(8'h2D);
        get(csr_i[15:8]);
        get(csr_i[7:0]);
        $display("status test done");
        idle();
        hs_en_i <= 1'b1;
        background_debug_mode_i <= 1'b1;
        send(8'h01);
        for (int i = 2; i >= 0; i--) get(cpu_pc_next_i[8*i +: 8]);
        chk("ack count", 24'h1, acks[23:0]);
        $display("pc test done");
        idle();
        for (int p = 0; p < 2; p++) begin
            send(8'h07);
            for (int i = 7; i >= 0; i--) get(w[8*i +: 8]);
            idle();
            hs_en_i <= 1'b0;
        end
        chk("ack count", 24'h3, acks[23:0]);
        $display("trace test done");
        send(8'h54);
        get(8'hEE);
        get(8'hEE);
        chk("illegal flag", 24'h1, {23'h0, illegal_command_flag_o});
        $display("repeat test done");
        idle();
        cpu_in_wait_i <= 1'b1;
        send(8'h01);
        for (int i = 0; i < 3; i++) get(8'hEE);
        chk("no response flag", 24'h1, {23'h0, no_response_flag_o});
        cpu_in_wait_i <= 1'b0;
        idle();
        send_seq(40'h11_0000_105A, 5);
        get(csr_i[7:0]);
        send_seq(40'h00_3812_3457, 4);
        for (int i = 3; i >= 0; i--) get(rd[8*i +: 8]);
        send(8'h00);
        send(8'h55);
        get(csr_i[7:0]);
        for (int i = 1; i >= 0; i--) get(rd[8*i +: 8]);
        $display("memory test done");
        idle();
        flag_clr_i <= 1'b1;
        background_debug_mode_i <= 1'b0;
        idle();
        flag_clr_i <= 1'b0;
        for (int i = 0; i < 5; i++) send(i == 0 ? 8'h40 : 8'h5A);
        idle();
        chk("register writes", 24'h0, writes[23:0]);
        chk("illegal flag", 24'h1, {23'h0, illegal_command_flag_o});
        background_debug_mode_i <= 1'b1;
        send_seq(40'h47_0102_0304, 5);
        idle();
        chk("register writes", 24'h1, writes[23:0]);
        chk("register data", 24'h020304, reg_wr_o.data[23:0]);
        $display("register test done");
        complete_run();
    end
endmodule : bdcx_engine_test
